// *** uopc_pkg.sv ***
// uopc_pkg: register map, field positions, reset values and timing for usb otg power control
// assumes a 32-bit apb slave with one aligned word per register
package uopc_pkg;
  localparam logic [11:0] OTG_LINE_CONTROL_ADDR = 12'h000;
  localparam logic [11:0] USB_POWER_CONTROL_ADDR = 12'h004;
  localparam logic [11:0] USB_ERROR_STATUS_ADDR = 12'h008;
  localparam logic [11:0] USB_LINE_STATUS_ADDR = 12'h00c;
  // otg line control fields
  localparam int DPLUS_PULLUP_BIT = 7;
  localparam int DMINUS_PULLUP_BIT = 6;
  localparam int DPLUS_PULLDOWN_BIT = 5;
  localparam int DMINUS_PULLDOWN_BIT = 4;
  localparam int VBUS_POWER_BIT = 3;
  localparam int SW_OWNERSHIP_BIT = 2;
  localparam int VBUS_CHARGE_BIT = 1;
  localparam int VBUS_DISCHARGE_BIT = 0;
  // power control fields
  localparam int ACTIVITY_PENDING_BIT = 7;
  localparam int SLEEP_GUARD_BIT = 4;
  localparam int MODULE_BUSY_BIT = 3;
  localparam int SUSPEND_BIT = 1;
  localparam int POWER_ON_BIT = 0;
  // error status fields
  localparam int BUS_TURNAROUND_BIT = 4;
  localparam int DMA_ERROR_BIT = 3;
  localparam int TOKEN_CRC_BIT = 1;
  localparam int PID_CHECK_BIT = 0;
  localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_CONTROL_MASK = 8'h13;
  localparam logic [7:0] ERROR_STATUS_MASK = 8'h1b;
  localparam int IMPL_WIDTH = 8;
  // timing: usb full-speed bit time and turnaround limit
  localparam int CLK_HZ = 10_000_000;
  localparam int BIT_RATE_HZ = 12_000_000;
  localparam int TURNAROUND_BIT_TIMES = 16;
  // more than 16 bit times means at least this many clocks of idle, never below one
  localparam int TURNAROUND_RAW = (TURNAROUND_BIT_TIMES * CLK_HZ) / BIT_RATE_HZ + 1;
  localparam int TURNAROUND_CYCLES = (TURNAROUND_RAW < 1) ? 1 : TURNAROUND_RAW;
  localparam int SHUTDOWN_CYCLES = 8;
endpackage : uopc_pkg

// *** uopc_otg_power_control.sv ***
// uopc_otg_power_control: apb register block for usb otg line and power control
// assumes usb core event inputs on clk; line pins and activity come from outside and are synced
//
// Summary of operation
// - control bit 7 drives d+ pull-up
// - control bit 6 drives d- pull-up
// - control bit 5 drives d+ pull-down
// - control bit 4 drives d- pull-down
// - bit 3 powers vbus
// - bit 2 selects software or hardware pulls
// - bit 1 charges vbus through pull-up
// - bit 0 discharges vbus through pull-down
// - read-only flag shows activity awaiting interrupt
// - guard bit blocks sleep on activity
// - busy reads 1 until ready to enable
// - suspend gates usb clock, transceiver low power
// - enable 0 holds pin outputs inactive, analog off; sleepBlocked still follows guard
// - device mode: bit 1 flags token crc5
// - host mode: bit 1 flags end-of-frame
// - bit 0 flags pid check failure
// - flag dma late grant or truncation
// - flag idle over 16 bit times
// - bits 31 to 8 read zero
`timescale 1ns/1ns
module uopc_otg_power_control #(
  parameter int TURNAROUND_CYCLES = uopc_pkg::TURNAROUND_CYCLES,
  parameter int SHUTDOWN_CYCLES = uopc_pkg::SHUTDOWN_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hostMode,
  input wire logic hwDplusPullupEn,
  input wire logic hwDminusPullupEn,
  input wire logic hwDplusPulldownEn,
  input wire logic hwDminusPulldownEn,
  input wire logic busActivityPin,
  input wire logic lineIdlePin,
  input wire logic eopSeen,
  input wire logic interruptIssued,
  input wire logic notifyPending,
  input wire logic moduleActive,
  input wire logic tokenCrc5Bad,
  input wire logic sofCountZero,
  input wire logic pidCheckBad,
  input wire logic dmaGrantLate,
  input wire logic bufferTruncated,
  input wire logic sleepRequest,
  output logic dplusPullupEn,
  output logic dminusPullupEn,
  output logic dplusPulldownEn,
  output logic dminusPulldownEn,
  output logic vbusPowerOn,
  output logic vbusChargeEn,
  output logic vbusDischargeEn,
  output logic usbClockEn,
  output logic transceiverLowPower,
  output logic analogEn,
  output logic pinsOwnedByUsb,
  output logic sleepBlocked
);
  initial begin
    if (TURNAROUND_CYCLES < 1 || TURNAROUND_CYCLES > 255) $error("turnaround count out of range");
    if (SHUTDOWN_CYCLES < 1 || SHUTDOWN_CYCLES > 255) $error("shutdown count out of range");
    // both counters are eight bits wide; the bounds above keep them from wrapping
    // every control and status field must sit in the implemented low byte
    if (uopc_pkg::IMPL_WIDTH != $bits(state_q.lineCtl)) begin
      $error("implemented width does not match the byte-wide fields");
    end
    if (uopc_pkg::DPLUS_PULLUP_BIT >= uopc_pkg::IMPL_WIDTH) begin
      $error("line control field outside low byte");
    end
    if (uopc_pkg::ACTIVITY_PENDING_BIT >= uopc_pkg::IMPL_WIDTH) begin
      $error("power control field outside low byte");
    end
    if (uopc_pkg::BUS_TURNAROUND_BIT >= $bits(state_q.errFlags)) begin
      $error("error field outside flag register");
    end
    // the decoder compares whole byte addresses, so each register must be word aligned
    if (uopc_pkg::OTG_LINE_CONTROL_ADDR[1:0] != 2'h0) begin
      $error("line control address not word aligned");
    end
    if (uopc_pkg::USB_POWER_CONTROL_ADDR[1:0] != 2'h0) begin
      $error("power control address not word aligned");
    end
    if (uopc_pkg::USB_ERROR_STATUS_ADDR[1:0] != 2'h0) begin
      $error("error status address not word aligned");
    end
    if (uopc_pkg::USB_LINE_STATUS_ADDR[1:0] != 2'h0) begin
      $error("line status address not word aligned");
    end
  end

  typedef enum logic [1:0] {
    UOPC_OFF = 2'b00,
    UOPC_ON = 2'b01,
    UOPC_DRAIN = 2'b10
  } uopc_pwr_e;

  typedef struct packed {
    logic [7:0] lineCtl;
    logic sleepGuard;
    logic suspendReq;
    logic powerOn;
    uopc_pwr_e pwrState;
    logic [7:0] drainCnt;
    logic activityPending;
    logic [4:0] errFlags;
    logic [7:0] idleCnt;
    logic idleArmed;
    logic [1:0] actSync;
    logic [1:0] idleSync;
    logic [31:0] rdata;
    // registered pin controls, one flop per output
    logic dplusUp;
    logic dminusUp;
    logic dplusDown;
    logic dminusDown;
    logic vbusPower;
    logic vbusCharge;
    logic vbusDischarge;
    logic clockRun;
  } uopc_state_s;

  uopc_state_s state_q;
  uopc_state_s state_d;

  logic wrEn;
  logic rdEn;
  logic mapped;
  logic busy;
  logic activity;
  logic lineIdle;
  logic [3:0] pulls;
  // idle count and its expiry are worked out once and shared by counter and flag
  logic [7:0] idleNext;
  logic idleExpired;

  // merge a written byte lane under a field mask, keeping unwritten bits
  function automatic logic [7:0] uopc_merge(input logic [7:0] old, input logic [7:0] wdat,
                                            input logic [7:0] mask, input logic lane);
    uopc_merge = lane ? ((old & ~mask) | (wdat & mask)) : old;
  endfunction : uopc_merge

  function automatic logic uopc_hit(input logic [11:0] a);
    uopc_hit = (a == uopc_pkg::OTG_LINE_CONTROL_ADDR) || (a == uopc_pkg::USB_POWER_CONTROL_ADDR)
      || (a == uopc_pkg::USB_ERROR_STATUS_ADDR) || (a == uopc_pkg::USB_LINE_STATUS_ADDR);
  endfunction : uopc_hit

  // one-step counter arithmetic, kept in one place so both counters agree on width
  function automatic logic [7:0] uopc_inc(input logic [7:0] c);
    uopc_inc = c + 8'h01;
  endfunction : uopc_inc

  function automatic logic [7:0] uopc_dec(input logic [7:0] c);
    uopc_dec = (c > 8'h01) ? c - 8'h01 : 8'h01;
  endfunction : uopc_dec

  assign activity = state_q.actSync[1];
  assign lineIdle = state_q.idleSync[1];
  assign mapped = uopc_hit(paddr);
  assign wrEn = psel && penable && pwrite && mapped;
  assign rdEn = psel && !penable && !pwrite;
  assign busy = (state_q.pwrState != UOPC_OFF);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = state_q.rdata;

  always_comb begin
    state_d = state_q;
    state_d.actSync = {state_q.actSync[0], busActivityPin};
    state_d.idleSync = {state_q.idleSync[0], lineIdlePin};

    // writes land at the access edge only; upper lanes hold nothing
    if (wrEn && paddr == uopc_pkg::OTG_LINE_CONTROL_ADDR) begin
      state_d.lineCtl = uopc_merge(state_q.lineCtl, pwdata[7:0], 8'hff, pstrb[0]);
    end
    if (wrEn && paddr == uopc_pkg::USB_POWER_CONTROL_ADDR && pstrb[0]) begin
      state_d.sleepGuard = pwdata[uopc_pkg::SLEEP_GUARD_BIT];
      state_d.suspendReq = pwdata[uopc_pkg::SUSPEND_BIT];
      state_d.powerOn = pwdata[uopc_pkg::POWER_ON_BIT];
    end

    // busy stays up after disable until the drain count expires and moduleActive is low
    case (state_q.pwrState)
      UOPC_OFF: begin
        if (state_d.powerOn) begin
          state_d.pwrState = UOPC_ON;
        end
      end
      UOPC_ON: begin
        if (!state_q.powerOn) begin
          state_d.pwrState = UOPC_DRAIN;
          state_d.drainCnt = 8'(SHUTDOWN_CYCLES);
        end
      end
      UOPC_DRAIN: begin
        if (state_q.powerOn) begin
          state_d.pwrState = UOPC_ON;
        end else if (state_q.drainCnt <= 8'h01 && !moduleActive) begin
          state_d.pwrState = UOPC_OFF;
        end else if (state_q.drainCnt > 8'h01) begin
          state_d.drainCnt = uopc_dec(state_q.drainCnt);
        end
      end
      default: begin
        state_d.pwrState = UOPC_OFF;
      end
    endcase

    // activity flag: set wins over the clear by the issued interrupt
    if (state_q.powerOn && activity) begin
      state_d.activityPending = 1'b1;
    end else if (interruptIssued) begin
      state_d.activityPending = 1'b0;
    end

    // idle counter from last eop; runs only while armed so the flag fires once
    // a new eop rearms the counter even while an older count is running
    idleNext = uopc_inc(state_q.idleCnt);
    idleExpired = !eopSeen && state_q.idleArmed && lineIdle
      && idleNext >= 8'(TURNAROUND_CYCLES);
    if (eopSeen) begin
      state_d.idleCnt = 8'h00;
      state_d.idleArmed = 1'b1;
    end else if (idleExpired) begin
      state_d.idleArmed = 1'b0;
    end else if (state_q.idleArmed && lineIdle) begin
      state_d.idleCnt = idleNext;
    end

    // error flags: write one to clear, a new event in the same cycle wins
    if (wrEn && paddr == uopc_pkg::USB_ERROR_STATUS_ADDR && pstrb[0]) begin
      state_d.errFlags = state_d.errFlags & ~pwdata[4:0];
    end
    if (dmaGrantLate || bufferTruncated) begin
      state_d.errFlags[uopc_pkg::DMA_ERROR_BIT] = 1'b1;
    end
    if ((!hostMode && tokenCrc5Bad) || (hostMode && sofCountZero && moduleActive)) begin
      state_d.errFlags[uopc_pkg::TOKEN_CRC_BIT] = 1'b1;
    end
    if (pidCheckBad) begin
      state_d.errFlags[uopc_pkg::PID_CHECK_BIT] = 1'b1;
    end
    if (idleExpired) begin
      state_d.errFlags[uopc_pkg::BUS_TURNAROUND_BIT] = 1'b1;
    end

    // read data captured in setup; high bits stay zero
    if (rdEn) begin
      state_d.rdata = 32'h0000_0000;
      case (paddr)
        uopc_pkg::OTG_LINE_CONTROL_ADDR: state_d.rdata[7:0] = state_q.lineCtl;
        uopc_pkg::USB_POWER_CONTROL_ADDR: begin
          state_d.rdata[uopc_pkg::ACTIVITY_PENDING_BIT] = state_q.activityPending;
          state_d.rdata[uopc_pkg::SLEEP_GUARD_BIT] = state_q.sleepGuard;
          state_d.rdata[uopc_pkg::MODULE_BUSY_BIT] = busy;
          state_d.rdata[uopc_pkg::SUSPEND_BIT] = state_q.suspendReq;
          state_d.rdata[uopc_pkg::POWER_ON_BIT] = state_q.powerOn;
        end
        uopc_pkg::USB_ERROR_STATUS_ADDR: state_d.rdata[4:0] = state_q.errFlags;
        uopc_pkg::USB_LINE_STATUS_ADDR: state_d.rdata[1:0] = {lineIdle, activity};
        default: state_d.rdata = 32'h0000_0000;
      endcase
    end

    // pull ownership: software bits or usb core requests
    pulls = state_q.lineCtl[uopc_pkg::SW_OWNERSHIP_BIT]
      ? state_q.lineCtl[7:4]
      : {hwDplusPullupEn, hwDminusPullupEn, hwDplusPulldownEn, hwDminusPulldownEn};
    // disabled module holds every pin output low
    if (!state_q.powerOn) begin
      state_d.dplusUp = 1'b0;
      state_d.dminusUp = 1'b0;
      state_d.dplusDown = 1'b0;
      state_d.dminusDown = 1'b0;
      state_d.vbusPower = 1'b0;
      state_d.vbusCharge = 1'b0;
      state_d.vbusDischarge = 1'b0;
      state_d.clockRun = 1'b0;
    end else begin
      state_d.dplusUp = pulls[3];
      state_d.dminusUp = pulls[2];
      state_d.dplusDown = pulls[1];
      state_d.dminusDown = pulls[0];
      state_d.vbusPower = state_q.lineCtl[uopc_pkg::VBUS_POWER_BIT];
      state_d.vbusCharge = state_q.lineCtl[uopc_pkg::VBUS_CHARGE_BIT];
      state_d.vbusDischarge = state_q.lineCtl[uopc_pkg::VBUS_DISCHARGE_BIT];
      state_d.clockRun = !state_q.suspendReq;
    end

    // every field named so a later addition cannot slip out of reset
    if (!reset_n) begin
      state_d.lineCtl = uopc_pkg::LINE_CONTROL_RESET;
      state_d.sleepGuard = 1'b0;
      state_d.suspendReq = 1'b0;
      state_d.powerOn = 1'b0;
      state_d.pwrState = UOPC_OFF;
      state_d.drainCnt = 8'h00;
      state_d.activityPending = 1'b0;
      state_d.errFlags = 5'h00;
      state_d.idleCnt = 8'h00;
      state_d.idleArmed = 1'b0;
      state_d.actSync = 2'h0;
      state_d.idleSync = 2'h0;
      state_d.rdata = 32'h0000_0000;
      state_d.dplusUp = 1'b0;
      state_d.dminusUp = 1'b0;
      state_d.dplusDown = 1'b0;
      state_d.dminusDown = 1'b0;
      state_d.vbusPower = 1'b0;
      state_d.vbusCharge = 1'b0;
      state_d.vbusDischarge = 1'b0;
      state_d.clockRun = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  assign dplusPullupEn = state_q.dplusUp;
  assign dminusPullupEn = state_q.dminusUp;
  assign dplusPulldownEn = state_q.dplusDown;
  assign dminusPulldownEn = state_q.dminusDown;
  assign vbusPowerOn = state_q.vbusPower;
  assign vbusChargeEn = state_q.vbusCharge;
  assign vbusDischargeEn = state_q.vbusDischarge;
  assign usbClockEn = state_q.clockRun;
  // low power follows the suspend bit itself, so power-up never shows a false suspend
  assign transceiverLowPower = state_q.powerOn && state_q.suspendReq;
  assign analogEn = state_q.powerOn;
  assign pinsOwnedByUsb = state_q.powerOn;
  // guard only blocks; a plain request passes when nothing is pending
  assign sleepBlocked = sleepRequest && state_q.sleepGuard
    && (activity || state_q.activityPending || notifyPending);
endmodule : uopc_otg_power_control

// *** uopc_far_end.sv ***
// uopc_far_end: cable-side peer that sends one short packet per start pulse
// assumes start is a one-cycle pulse on clk
`timescale 1ns/1ns
module uopc_far_end (
  input wire logic clk,
  input wire logic start,
  output logic busActivityPin,
  output logic lineIdlePin,
  output logic eopSeen
);
  int n = 0;
  // line reads idle only once the packet and its end marker are over
  always @(posedge clk) begin
    n <= start ? 5 : (n > 0 ? n - 1 : 0);
    busActivityPin <= start || n > 1;
    eopSeen <= n == 1;
    lineIdlePin <= n == 0 && !start;
  end
endmodule : uopc_far_end

// *** uopc_otg_power_control_chk.sv ***
// uopc_otg_power_control_chk: port assertions for usb otg power control
// assumes only the top module ports; bound below
`timescale 1ns/1ns
module uopc_otg_power_control_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sleepRequest,
  input wire logic vbusPowerOn,
  input wire logic usbClockEn,
  input wire logic transceiverLowPower,
  input wire logic analogEn,
  input wire logic pinsOwnedByUsb,
  input wire logic sleepBlocked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  upper_zero_a: assert property (prdata[31:8] == 24'h000000)
    else $error("upper bits set");
  read_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  unmapped_a: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
    else $error("unmapped accepted");
  pins_free_a: assert property (pinsOwnedByUsb == analogEn)
    else $error("pin ownership wrong");
  off_quiet_a: assert property (!analogEn [*2] |-> !(vbusPowerOn || usbClockEn))
    else $error("active while off");
  low_power_a: assert property (transceiverLowPower |-> analogEn)
    else $error("low power while off");
  clock_gate_a: assert property (transceiverLowPower [*2] |-> !usbClockEn)
    else $error("clock runs in suspend");
  clock_run_a: assert property ((analogEn && !transceiverLowPower) [*2] |-> usbClockEn)
    else $error("clock stopped while running");
  sleep_cause_a: assert property (sleepBlocked |-> sleepRequest)
    else $error("sleep blocked unasked");
endmodule : uopc_otg_power_control_chk
bind uopc_otg_power_control uopc_otg_power_control_chk u_chk (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .sleepRequest(sleepRequest), .vbusPowerOn(vbusPowerOn),
  .usbClockEn(usbClockEn), .transceiverLowPower(transceiverLowPower), .analogEn(analogEn),
  .pinsOwnedByUsb(pinsOwnedByUsb), .sleepBlocked(sleepBlocked));

// *** testbench.sv ***
// testbench: apb-driven checks of usb otg power control
// assumes a 10 MHz clk and the far-end peer for bus activity
`timescale 1ns/1ns
module testbench;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, hostMode = 0, start = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [8:0] ev = '0;
  logic [3:0] hw = 4'ha;
  logic [6:0] o;
  logic [7:0] v;
  logic pready, pslverr, err, act, idle, eop, uClk, lowP, anaEn, pins, blk;
  logic [8:0] pm [5] = '{9'h020, 9'h008, 9'h040, 9'h080, 9'h010};
  logic [4:0] ex [2][5] = '{'{5'h01, 5'h02, 5'h08, 5'h08, 5'h00},
    '{5'h01, 5'h00, 5'h08, 5'h08, 5'h02}};
  int mismatches = 0, samplesChecked = 0, cyc = 0;
  uopc_far_end peer (.clk(clk), .start(start), .busActivityPin(act), .lineIdlePin(idle),
    .eopSeen(eop));
  uopc_otg_power_control #(.SHUTDOWN_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hostMode(hostMode),
    .hwDplusPullupEn(hw[3]), .hwDminusPullupEn(hw[2]), .hwDplusPulldownEn(hw[1]),
    .hwDminusPulldownEn(hw[0]), .busActivityPin(act), .lineIdlePin(idle), .eopSeen(eop),
    .interruptIssued(ev[0]), .notifyPending(ev[1]), .moduleActive(ev[2]),
    .tokenCrc5Bad(ev[3]), .sofCountZero(ev[4]), .pidCheckBad(ev[5]), .dmaGrantLate(ev[6]),
    .bufferTruncated(ev[7]), .sleepRequest(ev[8]), .dplusPullupEn(o[6]),
    .dminusPullupEn(o[5]), .dplusPulldownEn(o[4]), .dminusPulldownEn(o[3]),
    .vbusPowerOn(o[2]), .vbusChargeEn(o[1]), .vbusDischargeEn(o[0]), .usbClockEn(uClk),
    .transceiverLowPower(lowP), .analogEn(anaEn), .pinsOwnedByUsb(pins), .sleepBlocked(blk));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    if (mismatches == 0 && samplesChecked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // starts on a fresh edge so psel is never driven twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    err = pslverr;
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n
  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    ev <= ev | m;
    @(posedge clk);
    ev <= ev & ~m;
    wait_n(2);
  endtask : pulse
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    xfer(1'b1, 12'h004, 32'h1);
    for (int i = 0; i < 8; i++) begin
      v = 8'h04 | (8'h01 << i);
      xfer(1'b1, 12'h000, {24'hffffff, v});
      wait_n(2);
      chk(32'(o), {25'h0, v[7:3], v[1:0]});
      rd(12'h000, {24'h0, v});
    end
    xfer(1'b1, 12'h000, 32'hfb);
    wait_n(2);
    chk(32'(o), {25'h0, hw, 3'h7});
    xfer(1'b1, 12'h004, 32'h3);
    wait_n(2);
    chk(32'({uClk, lowP}), 32'h1);
    for (int g = 1; g >= 0; g--) begin
      xfer(1'b1, 12'h004, {27'h0, g[0], 4'h1});
      ev <= 9'h104;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wait_n(4);
      chk(32'(blk), 32'(g));
      chk(32'({uClk, lowP}), 32'h2);
      wait_n(40);
      rd(12'h004, {24'h0, 8'h89 | {3'h0, g[0], 4'h0}});
      pulse(9'h001);
      chk(32'(blk), 32'h0);
      rd(12'h004, {27'h0, g[0], 4'h9});
    end
    rd(12'h008, 32'h10);
    for (int h = 0; h < 2; h++) begin
      xfer(1'b1, 12'h008, 32'h1b);
      hostMode <= h[0];
      for (int i = 0; i < 5; i++) begin
        pulse(pm[i]);
        rd(12'h008, 32'(ex[h][i]));
        xfer(1'b1, 12'h008, 32'h1b);
      end
    end
    xfer(1'b1, 12'h004, 32'h0);
    rd(12'h004, 32'h8);
    ev <= 9'h0;
    wait_n(1);
    chk(32'({o, uClk, anaEn, pins}), 32'h0);
    wait_n(10);
    rd(12'h004, 32'h0);
    rd(12'h010, 32'h0);
    chk(32'(err), 32'h1);
    conclude();
  end
endmodule : testbench
